// file: rtl/ciau_divider.sv
// Sequential signed 16-bit divider, restoring on magnitudes
`timescale 1ns/10ps
`include "ciau_params.svh"
module ciau_divider (
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire logic                   start,
    input  wire logic [15:0]            dividend,
    input  wire logic [15:0]            divisor,
    output logic                        done,
    output ciau_pkg::ciau_divres_type   result
);
    import ciau_pkg::*;

    logic        run_q;
    logic [4:0]  cnt_q;
    logic [15:0] quo_q;
    logic [16:0] rem_q;
    logic [15:0] dvs_q;
    logic        negq_q;
    logic        negr_q;
    logic        done_q;
    ciau_divres_type res_q;

    wire [15:0] mag_a    = dividend[15] ? 16'(-dividend) : dividend;
    wire [15:0] mag_b    = divisor[15] ? 16'(-divisor) : divisor;
    wire [16:0] rem_sh   = {rem_q[15:0], quo_q[15]};
    wire [17:0] trial    = {1'b0, rem_sh} - {2'b00, dvs_q};
    wire        fits     = ~trial[17];
    wire        last     = (cnt_q == `CIAU_DIV_STEPS);
    wire [15:0] quo_sign = negq_q ? 16'(-quo_q) : quo_q;
    wire [15:0] rem_sign = negr_q ? 16'(-rem_q[15:0]) : rem_q[15:0];

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run_q  <= 1'b0;
            cnt_q  <= 5'h00;
            quo_q  <= 16'h0000;
            rem_q  <= 17'h00000;
            dvs_q  <= 16'h0000;
            negq_q <= 1'b0;
            negr_q <= 1'b0;
            done_q <= 1'b0;
            res_q  <= '0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                run_q  <= 1'b1;
                cnt_q  <= 5'h00;
                quo_q  <= mag_a;
                rem_q  <= 17'h00000;
                dvs_q  <= mag_b;
                negq_q <= dividend[15] ^ divisor[15];
                negr_q <= dividend[15];
            end else if (run_q && last) begin
                run_q      <= 1'b0;
                done_q     <= 1'b1;
                res_q.quot <= quo_sign;
                res_q.rem  <= rem_sign;
            end else if (run_q) begin
                cnt_q <= cnt_q + 5'h01;
                quo_q <= {quo_q[14:0], fits};
                rem_q <= fits ? trial[16:0] : rem_sh;
            end
        end
    end

    assign done   = done_q;
    assign result = res_q;

endmodule : ciau_divider

// file: rtl/ciau_params.svh
// Register map, field positions, op codes and limits of the integer arithmetic unit
`ifndef CIAU_PARAMS_SVH
`define CIAU_PARAMS_SVH

`define CIAU_OFF_CMD      8'h00
`define CIAU_OFF_OPA      8'h04
`define CIAU_OFF_OPB      8'h08
`define CIAU_OFF_RES_LO   8'h0C
`define CIAU_OFF_RES_HI   8'h10
`define CIAU_OFF_FLAGS    8'h14
`define CIAU_OFF_IRQ_STAT 8'h18
`define CIAU_OFF_IRQ_MASK 8'h1C

`define CIAU_CMD_OP_LSB   0
`define CIAU_CMD_OP_MSB   2
`define CIAU_CMD_EXEC_BIT 4
`define CIAU_CMD_DSTK_BIT 5

`define CIAU_FLG_OUT_BIT   0
`define CIAU_FLG_CARRY_BIT 1
`define CIAU_FLG_ERR_BIT   2
`define CIAU_FLG_BUSY_BIT  3

`define CIAU_IRQ_DONE_BIT 0
`define CIAU_IRQ_OUT_BIT  1
`define CIAU_IRQ_ERR_BIT  2

`define CIAU_OP_DIV  3'h0
`define CIAU_OP_DADD 3'h1
`define CIAU_OP_DSUB 3'h2
`define CIAU_OP_ADDC 3'h3
`define CIAU_OP_SUBC 3'h4

`define CIAU_MAX32   32'h7FFFFFFF
`define CIAU_MIN32   32'h80000000
`define CIAU_MIN16   16'h8000
`define CIAU_NEG1_16 16'hFFFF
`define CIAU_ZERO16  16'h0000
`define CIAU_ZERO32  32'h00000000

`define CIAU_DIV_STEPS 5'h10

`endif

// file: rtl/ciau_pkg.sv
// Types shared by the integer arithmetic unit
package ciau_pkg;

    typedef enum logic {
        ST_IDLE,
        ST_DIV
    } ciau_state_type;

    typedef struct packed {
        logic       dst_k;
        logic       exec;
        logic [2:0] op;
    } ciau_cmd_type;

    typedef struct packed {
        logic [15:0] rem;
        logic [15:0] quot;
    } ciau_divres_type;

    typedef struct packed {
        logic err;
        logic out;
        logic done;
    } ciau_irq_type;

endpackage : ciau_pkg

// file: rtl/ciau_top.sv
// Integer arithmetic unit: division tail, saturating double-word, carry add/sub, APB slave
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "ciau_params.svh"
module ciau_top (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    import ciau_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    ciau_state_type  state_q;
    ciau_cmd_type    cmd_q;
    logic [31:0]     opa_q;
    logic [31:0]     opb_q;
    logic [15:0]     res_lo_q;
    logic [15:0]     res_hi_q;
    logic            out_q;
    logic            carry_q;
    logic            err_q;
    ciau_irq_type    irq_stat_q;
    ciau_irq_type    irq_mask_q;
    logic [31:0]     prdata_q;
    logic            div_done;
    ciau_divres_type div_res;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    wire access   = psel & penable;
    wire setup    = psel & ~penable;
    wire hit_cmd  = (paddr == `CIAU_OFF_CMD);
    wire hit_opa  = (paddr == `CIAU_OFF_OPA);
    wire hit_opb  = (paddr == `CIAU_OFF_OPB);
    wire hit_lo   = (paddr == `CIAU_OFF_RES_LO);
    wire hit_hi   = (paddr == `CIAU_OFF_RES_HI);
    wire hit_flg  = (paddr == `CIAU_OFF_FLAGS);
    wire hit_ist  = (paddr == `CIAU_OFF_IRQ_STAT);
    wire hit_imsk = (paddr == `CIAU_OFF_IRQ_MASK);
    wire hit_any  = hit_cmd | hit_opa | hit_opb | hit_lo | hit_hi | hit_flg | hit_ist | hit_imsk;
    wire wr_ok    = access & pwrite & hit_any;
    wire busy     = (state_q == ST_DIV);

    // Operand and command writes during a division are dropped so the
    // in-flight divide and its destination stay consistent
    wire wr_cmd   = wr_ok & hit_cmd & ~busy;
    wire wr_opa   = wr_ok & hit_opa & ~busy;
    wire wr_opb   = wr_ok & hit_opb & ~busy;
    wire wr_flg   = wr_ok & hit_flg;
    wire wr_ist   = wr_ok & hit_ist;
    wire wr_imsk  = wr_ok & hit_imsk;

    ciau_cmd_type new_cmd;
    assign new_cmd.op    = pwdata[`CIAU_CMD_OP_MSB:`CIAU_CMD_OP_LSB];
    assign new_cmd.exec  = pwdata[`CIAU_CMD_EXEC_BIT];
    assign new_cmd.dst_k = pwdata[`CIAU_CMD_DSTK_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Operands: upper half of a pair in the high 16 bits

    wire [15:0] a16 = opa_q[15:0];
    wire [15:0] b16 = opb_q[15:0];
    wire [31:0] a32 = opa_q;
    wire [31:0] b32 = opb_q;

    ////////////////////////////////////////////////////////////////////////////
    // Saturating double-word add and subtract

    wire [32:0] dsum  = {a32[31], a32} + {b32[31], b32};
    wire [32:0] ddif  = {a32[31], a32} - {b32[31], b32};
    wire        op_sub = (new_cmd.op == `CIAU_OP_DSUB);
    wire [32:0] dwide = op_sub ? ddif : dsum;
    wire        dovf  = dwide[32] ^ dwide[31];
    wire [31:0] dsat  = !dovf ? dwide[31:0] : (dwide[32] ? `CIAU_MIN32 : `CIAU_MAX32);

    ////////////////////////////////////////////////////////////////////////////
    // Carry add and borrow subtract

    wire [16:0] cf17  = {16'h0000, carry_q};
    wire [16:0] addu  = {1'b0, a16} + {1'b0, b16} + cf17;
    wire [16:0] adds  = {a16[15], a16} + {b16[15], b16} + cf17;
    wire [16:0] subu  = {1'b0, a16} - {1'b0, b16} - cf17;
    wire [16:0] subs  = {a16[15], a16} - {b16[15], b16} - cf17;
    wire        add_ovf = adds[16] ^ adds[15];
    wire        sub_ovf = subs[16] ^ subs[15];

    ////////////////////////////////////////////////////////////////////////////
    // Division special cases

    wire div_zero  = (b16 == `CIAU_ZERO16);
    wire div_spec  = (a16 == `CIAU_MIN16) && (b16 == `CIAU_NEG1_16);
    wire is_div    = (new_cmd.op == `CIAU_OP_DIV);
    wire div_start = wr_cmd & new_cmd.exec & is_div & ~div_zero & ~div_spec;

    ciau_divider u_divider (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .start    (div_start),
        .dividend (a16),
        .divisor  (b16),
        .done     (div_done),
        .result   (div_res)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Immediate execution outcome of a command write

    logic        imm_wr_lo;
    logic        imm_wr_hi;
    logic [15:0] imm_lo;
    logic [15:0] imm_hi;
    logic        imm_out;
    logic        imm_carry_upd;
    logic        imm_carry;
    logic        imm_err;

    always_comb begin
        imm_wr_lo     = 1'b0;
        imm_wr_hi     = 1'b0;
        imm_lo        = `CIAU_ZERO16;
        imm_hi        = `CIAU_ZERO16;
        imm_out       = 1'b0;
        imm_carry_upd = 1'b0;
        imm_carry     = 1'b0;
        imm_err       = 1'b0;
        if (new_cmd.exec) begin
            case (new_cmd.op)
                `CIAU_OP_DIV: begin
                    if (div_zero) begin
                        imm_err = 1'b1;
                    end else if (div_spec) begin
                        imm_wr_lo = 1'b1;
                        imm_wr_hi = ~new_cmd.dst_k;
                        imm_lo    = `CIAU_MIN16;
                        imm_hi    = `CIAU_ZERO16;
                        imm_out   = 1'b1;
                    end
                end
                `CIAU_OP_DADD, `CIAU_OP_DSUB: begin
                    imm_wr_lo = 1'b1;
                    imm_wr_hi = 1'b1;
                    imm_lo    = dsat[15:0];
                    imm_hi    = dsat[31:16];
                    imm_out   = dovf;
                end
                `CIAU_OP_ADDC: begin
                    imm_wr_lo     = 1'b1;
                    imm_lo        = addu[15:0];
                    imm_out       = add_ovf;
                    imm_carry_upd = 1'b1;
                    imm_carry     = addu[16];
                end
                `CIAU_OP_SUBC: begin
                    imm_wr_lo     = 1'b1;
                    imm_lo        = subu[15:0];
                    imm_out       = sub_ovf;
                    imm_carry_upd = 1'b1;
                    imm_carry     = subu[16];
                end
                default: begin
                    imm_out = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Completion events

    wire imm_done  = wr_cmd & ~div_start;
    wire div_fin   = busy & div_done;
    wire ev_done   = imm_done | div_fin;
    wire ev_out    = (imm_done & imm_out) | div_fin;
    wire ev_err    = wr_cmd & imm_err;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            cmd_q   <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (div_start) begin
                        state_q <= ST_DIV;
                        cmd_q   <= new_cmd;
                    end
                end
                ST_DIV: begin
                    if (div_done) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operand registers

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            opa_q <= `CIAU_ZERO32;
            opb_q <= `CIAU_ZERO32;
        end else begin
            if (wr_opa) begin
                opa_q <= pwdata;
            end
            if (wr_opb) begin
                opb_q <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result registers

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            res_lo_q <= `CIAU_ZERO16;
            res_hi_q <= `CIAU_ZERO16;
        end else if (div_fin) begin
            res_lo_q <= div_res.quot;
            if (!cmd_q.dst_k) begin
                res_hi_q <= div_res.rem;
            end
        end else if (wr_cmd) begin
            if (imm_wr_lo) begin
                res_lo_q <= imm_lo;
            end
            if (imm_wr_hi) begin
                res_hi_q <= imm_hi;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output flag and status flags; hardware set wins over a software clear

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            out_q <= 1'b0;
        end else if (div_fin) begin
            out_q <= 1'b1;
        end else if (wr_cmd) begin
            out_q <= imm_out;
        end
    end

    wire clr_carry = wr_flg & pwdata[`CIAU_FLG_CARRY_BIT];
    wire clr_err   = wr_flg & pwdata[`CIAU_FLG_ERR_BIT];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            carry_q <= 1'b0;
        end else if (wr_cmd && imm_carry_upd) begin
            carry_q <= imm_carry;
        end else if (clr_carry) begin
            carry_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            err_q <= 1'b0;
        end else if (ev_err) begin
            err_q <= 1'b1;
        end else if (clr_err) begin
            err_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky, write one to clear, set beats clear

    ciau_irq_type ev_vec;
    ciau_irq_type w1c_vec;
    assign ev_vec.done  = ev_done;
    assign ev_vec.out   = ev_out;
    assign ev_vec.err   = ev_err;
    assign w1c_vec.done = wr_ist & pwdata[`CIAU_IRQ_DONE_BIT];
    assign w1c_vec.out  = wr_ist & pwdata[`CIAU_IRQ_OUT_BIT];
    assign w1c_vec.err  = wr_ist & pwdata[`CIAU_IRQ_ERR_BIT];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            irq_stat_q <= ev_vec | (irq_stat_q & ~w1c_vec);
            if (wr_imsk) begin
                irq_mask_q <= pwdata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path, sampled in the setup phase so the access phase needs no wait

    wire [31:0] flags_word = {28'h0000000, busy, err_q, carry_q, out_q};
    wire [31:0] cmd_word   = {26'h0000000, cmd_q.dst_k, cmd_q.exec, 1'b0, cmd_q.op};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = `CIAU_ZERO32;
        if (hit_cmd) begin
            rd_mux = cmd_word;
        end else if (hit_opa) begin
            rd_mux = opa_q;
        end else if (hit_opb) begin
            rd_mux = opb_q;
        end else if (hit_lo) begin
            rd_mux = {16'h0000, res_lo_q};
        end else if (hit_hi) begin
            rd_mux = {16'h0000, res_hi_q};
        end else if (hit_flg) begin
            rd_mux = flags_word;
        end else if (hit_ist) begin
            rd_mux = {29'h00000000, irq_stat_q};
        end else if (hit_imsk) begin
            rd_mux = {29'h00000000, irq_mask_q};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata_q <= `CIAU_ZERO32;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = access & ~hit_any;
    assign irq     = |(irq_stat_q & irq_mask_q);

endmodule : ciau_top

// file: verif/ciau_chk.sv
// Checker: register-side results of the arithmetic unit against shadow arithmetic
`timescale 1ns/10ps
`include "ciau_params.svh"
module ciau_chk (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic [31:0] opa_q, opb_q, res_q;
    logic [1:0]  kind_q;
    logic        hi_v_q, out_v_q, out_q, cf_q, err_q;
    wire         wr_w   = psel & penable & pwrite;
    wire         rd_w   = psel & penable & !pwrite;
    wire [2:0]   op_w   = pwdata[2:0];
    wire         ex_w   = pwdata[4];
    wire         k_w    = pwdata[5];
    wire [32:0]  dw_w   = {opa_q[31], opa_q} + (op_w == `CIAU_OP_DSUB ? -{opb_q[31], opb_q} : {opb_q[31], opb_q});
    wire         dov_w  = dw_w[32] ^ dw_w[31];
    wire         sub_w  = op_w == `CIAU_OP_SUBC;
    wire [16:0]  u_w    = sub_w ? {1'b0, opa_q[15:0]} - {1'b0, opb_q[15:0]} - {16'h0, cf_q}
                                : {1'b0, opa_q[15:0]} + {1'b0, opb_q[15:0]} + {16'h0, cf_q};
    wire [16:0]  s_w    = sub_w ? {opa_q[15], opa_q[15:0]} - {opb_q[15], opb_q[15:0]} - {16'h0, cf_q}
                                : {opa_q[15], opa_q[15:0]} + {opb_q[15], opb_q[15:0]} + {16'h0, cf_q};
    wire         spec_w = opa_q[15:0] == `CIAU_MIN16 && opb_q[15:0] == `CIAU_NEG1_16;
    ////////////////////////////////////////
    // Shadow assumes no command is written while a division runs
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {opa_q, opb_q, res_q, kind_q, hi_v_q, out_v_q, out_q, cf_q, err_q} <= '0;
        end else begin
            if (wr_w && paddr == `CIAU_OFF_OPA) opa_q <= pwdata;
            if (wr_w && paddr == `CIAU_OFF_OPB) opb_q <= pwdata;
            if (wr_w && paddr == `CIAU_OFF_FLAGS && pwdata[1]) cf_q <= 1'b0;
            if (wr_w && paddr == `CIAU_OFF_FLAGS && pwdata[2]) err_q <= 1'b0;
            if (wr_w && paddr == `CIAU_OFF_CMD) begin
                out_v_q <= 1'b1;
                out_q   <= 1'b0;
                if (ex_w && (op_w == `CIAU_OP_DADD || op_w == `CIAU_OP_DSUB)) begin
                    res_q  <= dov_w ? (dw_w[32] ? `CIAU_MIN32 : `CIAU_MAX32) : dw_w[31:0];
                    kind_q <= 2'h1;
                    hi_v_q <= 1'b1;
                    out_q  <= dov_w;
                end else if (ex_w && (op_w == `CIAU_OP_ADDC || sub_w)) begin
                    res_q[15:0] <= u_w[15:0];
                    kind_q      <= 2'h2;
                    cf_q        <= u_w[16];
                    out_q       <= s_w[16] ^ s_w[15];
                end else if (ex_w && op_w == `CIAU_OP_DIV) begin
                    if (opb_q[15:0] == `CIAU_ZERO16) begin
                        err_q <= 1'b1;
                    end else if (spec_w) begin
                        res_q  <= {(k_w ? res_q[31:16] : 16'h0000), 16'h8000};
                        kind_q <= 2'h3;
                        hi_v_q <= hi_v_q | !k_w;
                        out_q  <= 1'b1;
                    end else begin
                        kind_q  <= 2'h0;
                        out_v_q <= 1'b0;
                        hi_v_q  <= hi_v_q & k_w;
                    end
                end
            end
        end
    end
    ////////////////////////////////////////
    AST_DW_LO: assert property (rd_w && paddr == `CIAU_OFF_RES_LO && kind_q == 2'h1 |->
        prdata == {16'h0000, res_q[15:0]}) else $error("Double-word low half wrong");
    AST_RES_HI: assert property (rd_w && paddr == `CIAU_OFF_RES_HI && hi_v_q |->
        prdata == {16'h0000, res_q[31:16]}) else $error("High result register wrong");
    AST_CARRY_RES: assert property (rd_w && paddr == `CIAU_OFF_RES_LO && kind_q == 2'h2 |->
        prdata == {16'h0000, res_q[15:0]}) else $error("Carry add or subtract result wrong");
    AST_SPECIAL: assert property (rd_w && paddr == `CIAU_OFF_RES_LO && kind_q == 2'h3 |->
        prdata == 32'h00008000) else $error("Minimum over minus one quotient wrong");
    AST_OUT: assert property (rd_w && paddr == `CIAU_OFF_FLAGS && out_v_q |->
        prdata[0] == out_q) else $error("Output flag wrong");
    AST_CARRY_FLAG: assert property (rd_w && paddr == `CIAU_OFF_FLAGS |->
        prdata[1] == cf_q) else $error("Carry flag wrong");
    AST_ERR_FLAG: assert property (rd_w && paddr == `CIAU_OFF_FLAGS |->
        prdata[2] == err_q) else $error("Error flag wrong");
    AST_IRQ_MASK: assert property (wr_w && paddr == `CIAU_OFF_IRQ_MASK && pwdata[2:0] == 3'h0 |=>
        !irq [*2]) else $error("Interrupt high while fully masked");
    cover property (wr_w && paddr == `CIAU_OFF_CMD && ex_w && dov_w && op_w == `CIAU_OP_DSUB);
    cover property (rd_w && paddr == `CIAU_OFF_RES_LO && kind_q == 2'h3);
    cover property (rd_w && paddr == `CIAU_OFF_FLAGS && err_q && cf_q == 1'b0);
endmodule : ciau_chk
bind ciau_top ciau_chk ciau_chk_inst (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// file: verif/ciau_host_model.sv
// Host model: the instruction sequencer issuing register transfers to the unit
`timescale 1ns/10ps
module ciau_host_model (
    input  wire logic        clk_sys,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    ////////////////////////////////////////
    // Entered just after a rising edge; an idle cycle follows each transfer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output bit ok);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 64) begin
            n++;
            @(posedge clk_sys);
        end
        r  = prdata;
        e  = pslverr;
        ok = pready === 1'b1;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data must not look valid
        pwdata  <= ~d;
        @(posedge clk_sys);
    endtask : xfer
endmodule : ciau_host_model

// file: verif/ciau_tb_top.sv
// Testbench: register-level sequences for the integer arithmetic unit
`timescale 1ns/10ps
`include "ciau_params.svh"
module ciau_tb_top;
    localparam logic [7:0] FLG = `CIAU_OFF_FLAGS;
    localparam logic [7:0] RLO = `CIAU_OFF_RES_LO;
    localparam logic [7:0] RHI = `CIAU_OFF_RES_HI;
    localparam logic [7:0] IST = `CIAU_OFF_IRQ_STAT;
    localparam logic [7:0] IMK = `CIAU_OFF_IRQ_MASK;
    logic        clk_sys = 1'b0;
    logic        rstn    = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, irq, serr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    int          error_cnt = 0;
    int          checks    = 0;
    always #12.5 clk_sys = ~clk_sys;
    ciau_top ciau_top_inst (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    ciau_host_model ciau_host_model_inst (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////
    task automatic conclude();
        $display("Compares %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        bit ok;
        ciau_host_model_inst.xfer(w, a, d, q, serr, ok);
        if (!ok) begin
            error_cnt++;
            $display("FAIL %0t no answer on register bus", $time);
            conclude();
        end
    endtask : acc
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rc
    task automatic op(input logic [31:0] a, b, input logic k, e, input logic [2:0] c);
        acc(1'b1, `CIAU_OFF_OPA, a);
        acc(1'b1, `CIAU_OFF_OPB, b);
        acc(1'b1, `CIAU_OFF_CMD, {26'h0, k, e, 1'b0, c});
    endtask : op
    task automatic dw(input logic [2:0] c, input logic [31:0] a, b, ex, input logic o);
        acc(1'b1, FLG, 32'h6);
        op(a, b, 1'b0, 1'b1, c);
        rc(RLO, {16'h0, ex[15:0]});
        rc(RHI, {16'h0, ex[31:16]});
        rc(FLG, {31'h0, o});
    endtask : dw
    task automatic c16(input logic [2:0] c, input logic [15:0] a, b, r, input logic cf, o);
        op({16'h0, a}, {16'h0, b}, 1'b0, 1'b1, c);
        rc(RLO, {16'h0, r});
        rc(FLG, {30'h0, cf, o});
    endtask : c16
    task automatic dv(input logic [15:0] a, b, input logic k, input logic [15:0] lo, hi);
        int n;
        n = 0;
        op({16'h0, a}, {16'h0, b}, k, 1'b1, `CIAU_OP_DIV);
        q = 32'h8;
        while (q[3] !== 1'b0 && n < 40) begin
            acc(1'b0, FLG, 32'h0);
            n++;
        end
        check({31'h0, q[3]}, 32'h0);
        if (q[3] !== 1'b0) conclude();
        rc(RLO, {16'h0, lo});
        rc(RHI, {16'h0, hi});
    endtask : dv
    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rc(FLG, 32'h0);
        rc(IST, 32'h0);
        acc(1'b1, IMK, 32'h7);
        dw(`CIAU_OP_DADD, 32'h000493E0, 32'h000186A0, 32'h00061A80, 1'b0);
        dw(`CIAU_OP_DADD, 32'h7FFFFFFF, 32'h00000001, `CIAU_MAX32, 1'b1);
        dw(`CIAU_OP_DADD, 32'h80000000, 32'hFFFFFFFF, `CIAU_MIN32, 1'b1);
        dw(`CIAU_OP_DSUB, 32'h00181BE0, 32'h00013880, 32'h0016E360, 1'b0);
        dw(`CIAU_OP_DSUB, 32'h80000000, 32'h00000001, `CIAU_MIN32, 1'b1);
        dw(`CIAU_OP_DSUB, 32'h7FFFFFFF, 32'hFFFFFFFF, `CIAU_MAX32, 1'b1);
        acc(1'b1, FLG, 32'h2);
        c16(`CIAU_OP_ADDC, 16'h614E, 16'hD432, 16'h3580, 1'b1, 1'b0);
        c16(`CIAU_OP_ADDC, 16'h00BC, 16'h0000, 16'h00BD, 1'b0, 1'b0);
        c16(`CIAU_OP_ADDC, 16'h8000, 16'h8000, 16'h0000, 1'b1, 1'b1);
        c16(`CIAU_OP_ADDC, 16'h7FFF, 16'h0000, 16'h8000, 1'b0, 1'b1);
        acc(1'b1, FLG, 32'h2);
        c16(`CIAU_OP_SUBC, 16'h614E, 16'h4B20, 16'h162E, 1'b0, 1'b0);
        c16(`CIAU_OP_SUBC, 16'h00BC, 16'h00BC, 16'h0000, 1'b0, 1'b0);
        c16(`CIAU_OP_SUBC, 16'h0000, 16'h0001, 16'hFFFF, 1'b1, 1'b0);
        acc(1'b1, `CIAU_OFF_CMD, {26'h0, 2'b00, 1'b0, `CIAU_OP_ADDC});
        rc(RLO, 32'h0000FFFF);
        rc(FLG, 32'h2);
        c16(`CIAU_OP_SUBC, 16'h8000, 16'h0000, 16'h7FFF, 1'b0, 1'b1);
        op(32'h1234, 32'h0, 1'b0, 1'b1, `CIAU_OP_DIV);
        rc(FLG, 32'h4);
        check({31'h0, irq}, 32'h1);
        acc(1'b1, `CIAU_OFF_CMD, {26'h0, 2'b00, 1'b0, `CIAU_OP_ADDC});
        rc(FLG, 32'h4);
        acc(1'b1, FLG, 32'h4);
        rc(FLG, 32'h0);
        acc(1'b1, IST, 32'h7);
        check({31'h0, irq}, 32'h0);
        acc(1'b1, IMK, 32'h0);
        acc(1'b1, `CIAU_OFF_CMD, {26'h0, 2'b00, 1'b0, `CIAU_OP_ADDC});
        check({31'h0, irq}, 32'h0);
        rc(IST, 32'h1);
        acc(1'b1, IMK, 32'h1);
        check({31'h0, irq}, 32'h1);
        acc(1'b1, IST, 32'h1);
        check({31'h0, irq}, 32'h0);
        dv(16'h8000, 16'hFFFF, 1'b0, 16'h8000, 16'h0000);
        dv(16'hFFF9, 16'h0002, 1'b0, 16'hFFFD, 16'hFFFF);
        dv(16'h0B4E, 16'h0145, 1'b1, 16'h0008, 16'hFFFF);
        dv(16'h0B4E, 16'h0145, 1'b0, 16'h0008, 16'h0126);
        acc(1'b0, 8'h20, 32'h0);
        check({31'h0, serr}, 32'h1);
        check(q, 32'h0);
        conclude();
    end
endmodule : ciau_tb_top
